// *** common/pfels_pkg.sv ***
// constants for the pin function and external line select block
// assumes a 32-bit apb slave port on a single clock
package pfels_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [11:0] OFF_LINE_SEL_0   = 12'h000; // lines 0..7
    localparam logic [11:0] OFF_LINE_SEL_1   = 12'h004; // lines 8..15
    localparam logic [11:0] OFF_PORT_A_LOW   = 12'h020;
    localparam logic [11:0] OFF_PORT_A_HIGH  = 12'h024;
    localparam logic [11:0] OFF_PORT_B_LOW   = 12'h028;
    localparam logic [11:0] OFF_PORT_B_HIGH  = 12'h02C;
    localparam logic [11:0] OFF_PORT_C_LOW   = 12'h030;
    localparam logic [11:0] OFF_PORT_C_HIGH  = 12'h034;
    // ************************************************************
    // field layout and values
    // ************************************************************
    localparam int          SEL_W            = 4;        // selector width
    localparam int          PINS             = 16;       // pins per port
    localparam int          LINES            = 16;       // interrupt lines
    localparam logic [31:0] REG_RESET        = 32'h0000_0000;
    localparam logic [3:0]  DEFAULT_FUNCTION = 4'h0;
    localparam logic [3:0]  SRC_PORT_A       = 4'h0;
    localparam logic [3:0]  SRC_PORT_B       = 4'h1;
    localparam logic [3:0]  SRC_PORT_C       = 4'h2;
endpackage : pfels_pkg

// *** design/pfels_top.sv ***
// pin function multiplexer selectors and external line source routing
// assumes apb master on clk_in; pad inputs are already synchronised
`timescale 1ns/1ps
module pfels_top #(
    parameter logic [15:0] PORT_A_PRESENT = 16'hFFFF, // pins bonded out
    parameter logic [15:0] PORT_B_PRESENT = 16'hFFFF,
    parameter logic [15:0] PORT_C_PRESENT = 16'h00FF,
    parameter logic [15:0] FUNC_IMPL      = 16'hFFFF  // functions implemented
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // apb slave
    input  wire logic         psel_in,
    input  wire logic         penable_in,
    input  wire logic         pwrite_in,
    input  wire logic [11:0]  paddr_in,
    input  wire logic [31:0]  pwdata_in,
    output logic      [31:0]  prdata_out,
    output logic              pready_out,
    output logic              pslverr_out,
    // lock masks from the port lock registers
    input  wire logic [15:0]  lock_a_in,
    input  wire logic [15:0]  lock_b_in,
    input  wire logic [15:0]  lock_c_in,
    // pad input levels
    input  wire logic [15:0]  port_a_in,
    input  wire logic [15:0]  port_b_in,
    input  wire logic [15:0]  port_c_in,
    // effective selectors, four bits per pin
    output logic      [63:0]  func_a_out,
    output logic      [63:0]  func_b_out,
    output logic      [63:0]  func_c_out,
    // external interrupt lines
    output logic      [15:0]  ext_line_out
);
    // ************************************************************
    // register storage
    // ************************************************************
    logic [31:0] regs [8];            // source 0,1 then a lo/hi, b, c
    logic [31:0] rd_data;             // decoded read word
    logic        rd_hit;              // address maps a register
    logic [2:0]  rd_idx;              // register index
    logic        wr_phase;            // apb access phase write
    logic [15:0] lock_bits [3];       // lock mask per port
    logic [15:0] pres_bits [3];       // present mask per port
    logic [63:0] func_eff  [3];       // effective selectors
    logic [15:0] next_line;           // routed lines

    assign lock_bits[0] = lock_a_in;
    assign lock_bits[1] = lock_b_in;
    assign lock_bits[2] = lock_c_in;
    assign pres_bits[0] = PORT_A_PRESENT;
    assign pres_bits[1] = PORT_B_PRESENT;
    assign pres_bits[2] = PORT_C_PRESENT;

    // ************************************************************
    // address decode
    // ************************************************************
    // offsets to index
    assign rd_hit = (paddr_in == pfels_pkg::OFF_LINE_SEL_0)
                 || (paddr_in == pfels_pkg::OFF_LINE_SEL_1)
                 || ((paddr_in >= pfels_pkg::OFF_PORT_A_LOW)
                  && (paddr_in <= pfels_pkg::OFF_PORT_C_HIGH)
                  && (paddr_in[1:0] == 2'b00));
    assign rd_idx = (paddr_in < pfels_pkg::OFF_PORT_A_LOW) ? {2'b00, paddr_in[2]}
                  : 3'(((paddr_in - pfels_pkg::OFF_PORT_A_LOW) >> 2) + 12'd2);
    assign rd_data  = rd_hit ? regs[rd_idx] : 32'h0000_0000;
    assign wr_phase = psel_in && penable_in && pwrite_in && rd_hit;

    // ************************************************************
    // apb answer: zero wait states, unmapped reads zero, no error
    // ************************************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            // registered answer: ready in the cycle after setup
            pready_out  <= psel_in && !penable_in;
            prdata_out  <= rd_data;
            pslverr_out <= 1'b0;
        end
    end

    // ************************************************************
    // selector registers, one 4-bit field per pin or line
    // ************************************************************
    genvar r, f;
    generate
        for (r = 0; r < 8; r++) begin : g_reg
            for (f = 0; f < 8; f++) begin : g_fld
                localparam int PIN = ((r % 2) * 8) + f;
                logic locked;     // field frozen by port lock
                if (r >= 2) begin : g_lk
                    // lock masks for function registers only
                    assign locked = lock_bits[(r - 2) / 2][PIN];
                end else begin : g_nolk
                    // source selectors are never locked, and a separate
                    // branch keeps the lock index from going negative
                    assign locked = 1'b0;
                end
                always_ff @(posedge clk_in or posedge rst_in) begin
                    if (rst_in) begin
                        regs[r][4*f +: 4] <= pfels_pkg::REG_RESET[4*f +: 4];
                    end else if (wr_phase && pready_out && rd_idx == 3'(r) && !locked) begin
                        regs[r][4*f +: 4] <= pwdata_in[4*f +: 4];
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // effective function selectors per pin
    // ************************************************************
    genvar p, n;
    generate
        for (p = 0; p < 3; p++) begin : g_port
            for (n = 0; n < 16; n++) begin : g_pin
                logic [3:0] sel;  // stored selector
                assign sel = regs[2 + 2*p + n/8][4*(n%8) +: 4];
                assign func_eff[p][4*n +: 4] = FUNC_IMPL[sel] ? sel
                                             : pfels_pkg::DEFAULT_FUNCTION;
            end
        end
    endgenerate

    // ************************************************************
    // external line routing
    // ************************************************************
    genvar l;
    generate
        for (l = 0; l < 16; l++) begin : g_line
            logic [3:0] src;  // line port selector
            assign src = regs[l/8][4*(l%8) +: 4];
            // absent pin or reserved drives low
            assign next_line[l] =
                (src == pfels_pkg::SRC_PORT_A) ? (port_a_in[l] & pres_bits[0][l]) :
                (src == pfels_pkg::SRC_PORT_B) ? (port_b_in[l] & pres_bits[1][l]) :
                (src == pfels_pkg::SRC_PORT_C) ? (port_c_in[l] & pres_bits[2][l]) :
                1'b0;
        end
    endgenerate

    // ************************************************************
    // output registers
    // ************************************************************
    // forward routed pins
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            func_a_out   <= 64'h0;
            func_b_out   <= 64'h0;
            func_c_out   <= 64'h0;
            ext_line_out <= 16'h0000;
        end else begin
            func_a_out   <= func_eff[0];
            func_b_out   <= func_eff[1];
            func_c_out   <= func_eff[2];
            ext_line_out <= next_line;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_write_a_low;
        wr_phase && pready_out && rd_idx == 3'd2 && lock_a_in == 16'h0000;
    endsequence
    a_func_after_write: assert property (@(posedge clk_in) disable iff (rst_in)
        s_write_a_low ##2 1'b1 |-> (func_a_out[3:0] == (FUNC_IMPL[$past(pwdata_in[3:0], 2)]
            ? $past(pwdata_in[3:0], 2) : 4'h0)))
        else $error("function select not applied");
    a_lock_holds_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (lock_a_in[0] && $past(lock_a_in[0])) |-> $stable(regs[2][3:0]))
        else $error("locked selector changed");
    a_line_port_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (regs[0][3:0] == 4'h0) |=> (ext_line_out[0] == ($past(port_a_in[0]) & PORT_A_PRESENT[0])))
        else $error("line 0 not from port a");
    a_line_port_b: assert property (@(posedge clk_in) disable iff (rst_in)
        (regs[1][3:0] == 4'h1) |=> (ext_line_out[8] == ($past(port_b_in[8]) & PORT_B_PRESENT[8])))
        else $error("line 8 not from port b");
    a_line_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
        (regs[0][7:4] > 4'h2) |=> !ext_line_out[1])
        else $error("reserved source drove line");
    a_unimpl_default: assert property (@(posedge clk_in) disable iff (rst_in)
        !FUNC_IMPL[regs[4][3:0]] |=> (func_b_out[3:0] == 4'h0))
        else $error("unimplemented function reached pin");
    a_apb_ready: assert property (@(posedge clk_in) disable iff (rst_in)
        (psel_in && !penable_in) |=> pready_out)
        else $error("apb ready missing");
    a_read_back: assert property (@(posedge clk_in) disable iff (rst_in)
        (psel_in && !penable_in && paddr_in == 12'h030) |=> (prdata_out == $past(regs[6])))
        else $error("read data mismatch");

    // ************************************************************
    // further checks on bus, lock, routing, selectors and reset state
    // ************************************************************
    // the lock, routing and selector checks watch single pins and lines as samples of the generate
    // loops; a slip in the field arithmetic shows on them first

    // locked write to port a pin 0
    sequence s_locked_write_a0;
        wr_phase && pready_out && rd_idx == 3'd2 && lock_a_in[0];
    endsequence

    a_locked_write_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        s_locked_write_a0 |=> (regs[2][3:0] == $past(regs[2][3:0])))
        else $error("locked field took a write");

    a_slverr_low: assert property (@(posedge clk_in) disable iff (rst_in)
        !pslverr_out)
        else $error("apb error raised");

    a_ready_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        !psel_in |=> !pready_out)
        else $error("ready without setup");

    a_ready_single: assert property (@(posedge clk_in) disable iff (rst_in)
        pready_out |=> !pready_out)
        else $error("ready held too long");

    a_unmapped_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        (psel_in && !penable_in && paddr_in == 12'h008) |=> (prdata_out == 32'h0000_0000))
        else $error("unmapped read not zero");

    a_regs_after_reset: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(rst_in) |-> (regs[0] == pfels_pkg::REG_RESET && regs[7] == pfels_pkg::REG_RESET))
        else $error("register not cleared by reset");

    a_default_after_reset: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(rst_in) |-> (func_a_out == 64'h0 && func_c_out == 64'h0))
        else $error("pin not at default after reset");

    // port c source on line 0
    a_line_port_c: assert property (@(posedge clk_in) disable iff (rst_in)
        (regs[0][3:0] == 4'h2) |=> (ext_line_out[0] == ($past(port_c_in[0]) & PORT_C_PRESENT[0])))
        else $error("line 0 not from port c");

    // absent port c pin on line 8
    a_line_port_c_hi: assert property (@(posedge clk_in) disable iff (rst_in)
        (regs[1][3:0] == 4'h2) |=> (ext_line_out[8] == ($past(port_c_in[8]) & PORT_C_PRESENT[8])))
        else $error("line 8 port c routing wrong");

    a_line_top_b: assert property (@(posedge clk_in) disable iff (rst_in)
        (regs[1][31:28] == 4'h1) |=> (ext_line_out[15] == ($past(port_b_in[15]) & PORT_B_PRESENT[15])))
        else $error("line 15 not from port b");

    a_line_top_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
        (regs[1][31:28] > 4'h2) |=> !ext_line_out[15])
        else $error("reserved source drove line 15");

    a_func_a_top: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> (func_a_out[63:60] == (FUNC_IMPL[$past(regs[3][31:28])]
            ? $past(regs[3][31:28]) : 4'h0)))
        else $error("pin 15 selector wrong");

    // port c pin 8 in high word
    a_func_c_pin8: assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> (func_c_out[35:32] == (FUNC_IMPL[$past(regs[7][3:0])]
            ? $past(regs[7][3:0]) : 4'h0)))
        else $error("pin 8 field misplaced");
endmodule : pfels_top

// *** tb/pfels_pads.sv ***
// pad level source standing in for the three gpio ports
// assumes the bench calls shuffle between checks; levels stay put otherwise
`timescale 1ns/1ps
module pfels_pads (
    // pad levels towards the block
    output logic [15:0] pad_a_out,
    output logic [15:0] pad_b_out,
    output logic [15:0] pad_c_out
);
    int seed = 1; // fixed seed, runs repeat exactly
    initial begin
        pad_a_out = 16'h0000;
        pad_b_out = 16'h0000;
        pad_c_out = 16'h0000;
    end
    task automatic shuffle();
        pad_a_out = $random(seed);
        pad_b_out = $random(seed);
        pad_c_out = $random(seed); // absent pins toggle too, must not leak
    endtask : shuffle
endmodule : pfels_pads

// *** tb/pin_function_and_ext_line_select_tb.sv ***
// self-checking bench: apb tasks, integer model, pad source
// assumes default pad presence and a reduced set of implemented functions
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module pin_function_and_ext_line_select_tb;
    localparam logic [15:0] IMPL = 16'h37FF; // functions 11,14,15 absent
    localparam logic [15:0] PC   = 16'h00FF; // port c bonded pins
    logic clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, mdl[8];
    logic        pready, pslverr;
    logic [15:0] lock_a = 0, lock_b = 0, lock_c = 0, pa, pb, pc, ext;
    logic [63:0] fa, fb, fc;
    logic [11:0] offs[8] = '{pfels_pkg::OFF_LINE_SEL_0, pfels_pkg::OFF_LINE_SEL_1,
        pfels_pkg::OFF_PORT_A_LOW, pfels_pkg::OFF_PORT_A_HIGH, pfels_pkg::OFF_PORT_B_LOW,
        pfels_pkg::OFF_PORT_B_HIGH, pfels_pkg::OFF_PORT_C_LOW, pfels_pkg::OFF_PORT_C_HIGH};
    int fail_count = 0, n_compared = 0, seed = 1;
    always #50 clk_in = ~clk_in;
    pfels_pads pfels_pads_inst (.pad_a_out(pa), .pad_b_out(pb), .pad_c_out(pc));
    pfels_top #(.FUNC_IMPL(IMPL)) pfels_top_inst (.clk_in(clk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .lock_a_in(lock_a), .lock_b_in(lock_b),
        .lock_c_in(lock_c), .port_a_in(pa), .port_b_in(pb), .port_c_in(pc),
        .func_a_out(fa), .func_b_out(fb), .func_c_out(fc), .ext_line_out(ext));
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // one apb transfer, request held until the edge that samples ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i;
        @(posedge clk_in); #1;
        psel = 1; pen = 0; pwr = w; paddr = a; pwdata = d;
        @(posedge clk_in); #1;
        pen = 1;
        for (i = 0; i < 8 && pready !== 1'b1; i++) @(posedge clk_in) #1;
        if (i == 8) begin fail_count++; summarize(); end
        q = prdata;
        `CHK("pslverr", 1'b0, pslverr)
        @(posedge clk_in); #1;
        psel = 0; pen = 0;
    endtask : apb
    task automatic wr(input int i, input logic [31:0] d);
        logic [31:0] q, m;
        logic [15:0] lk;
        lk = (i < 2) ? 16'h0000 : (i < 4) ? lock_a : (i < 6) ? lock_b : lock_c;
        for (int p = 0; p < 8; p++) m[4*p+:4] = {4{lk[(i%2)*8+p]}};
        mdl[i] = (mdl[i] & m) | (d & ~m);
        apb(1'b1, offs[i], d, q);
    endtask : wr
    function automatic logic [63:0] eff(input logic [31:0] lo, input logic [31:0] hi);
        logic [63:0] r;
        r = {hi, lo};
        for (int p = 0; p < 16; p++) if (!IMPL[r[4*p+:4]]) r[4*p+:4] = 4'h0;
        return r;
    endfunction : eff
    function automatic logic [15:0] route();
        logic [63:0] s;
        logic [15:0] r;
        s = {mdl[1], mdl[0]};
        r = 16'h0000;
        for (int n = 0; n < 16; n++)
            case (s[4*n+:4])
                4'h0: r[n] = pa[n];
                4'h1: r[n] = pb[n];
                4'h2: r[n] = pc[n] & PC[n];
                default: r[n] = 1'b0;
            endcase
        return r;
    endfunction : route
    // compare func outputs the cycle after the last write, then all regs and lines
    task automatic chk_all(input string t);
        logic [31:0] q;
        @(posedge clk_in);
        #1;
        `CHK("func_a", eff(mdl[2], mdl[3]), fa)
        `CHK("func_b", eff(mdl[4], mdl[5]), fb)
        `CHK("func_c", eff(mdl[6], mdl[7]), fc)
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, offs[i], 32'h0, q);
            `CHK("reg", mdl[i], q)
        end
        pfels_pads_inst.shuffle();
        repeat (2) @(posedge clk_in);
        #1;
        `CHK("ext_line", route(), ext)
        $display("test %s done", t);
    endtask : chk_all
    initial begin
        logic [31:0] q;
        for (int i = 0; i < 8; i++) mdl[i] = 32'h0;
        repeat (20) @(posedge clk_in);
        #1 rst_in = 0;
        chk_all("reset");
        apb(1'b1, 12'h008, 32'hFFFF_FFFF, q);
        apb(1'b0, 12'h008, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        for (int k = 0; k < 5; k++) begin
            wr(0, {8{k == 4 ? 4'hF : 4'(k)}});
            wr(1, $random(seed));
            chk_all("source");
        end
        for (int f = 0; f < 16; f++) begin
            wr(5, {8{4'(f)}});
            chk_all("function");
        end
        for (int r = 0; r < 6; r++) begin
            lock_a = $random(seed); lock_b = $random(seed); lock_c = $random(seed);
            for (int i = 0; i < 8; i++) wr(i, $random(seed));
            chk_all("lock");
        end
        rst_in = 1; lock_a = 0; lock_b = 0; lock_c = 0;
        for (int i = 0; i < 8; i++) mdl[i] = 32'h0;
        repeat (2) @(posedge clk_in);
        #1 rst_in = 0;
        chk_all("rereset");
        summarize();
    end
endmodule : pin_function_and_ext_line_select_tb
